// ===== pkg/asop_pkg.sv
// Constants shared by the converter sample output port
package asop_pkg;
	localparam int CODE_W = 10;
	localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
	localparam logic [CODE_W-1:0] CODE_ONES = 10'h3FF;
	localparam logic [CODE_W-1:0] CODE_TOP_MINUS1 = 10'h3FE;
	localparam int SAMPLE_LATENCY = 1;
	localparam int CLK_PERIOD_NS = 40;
	localparam int HIGH_MIN_NS = 20;
	localparam int HIGH_MAX_NS = 300;
	localparam int LOW_MIN_NS = 20;
	// Least times round up, longest round down, none below one cycle
	localparam int HIGH_MIN_CYC = (HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HIGH_MAX_CYC = HIGH_MAX_NS / CLK_PERIOD_NS;
	localparam int LOW_MIN_CYC = (LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_HIGH_MAX = 4'(HIGH_MAX_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
endpackage

// ===== rtl/asop_port.sv
// Sampling converter digital output port with two-entry output buffer
`timescale 1ns/1ps
`default_nettype none

module asop_port import asop_pkg::*; #(
	parameter int CODE_WIDTH = asop_pkg::CODE_W
) (
	// System
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Sampling clock pin and quantised analog input
	input wire logic sample_clk,
	input wire logic [asop_pkg::CODE_W-1:0] analog_level,
	input wire logic analog_over,
	// Result stream to the capturing logic
	output logic [asop_pkg::CODE_W-1:0] conversion_code,
	output logic overrange_flag,
	output logic result_valid,
	input wire logic result_ready,
	// Clock pulse width monitor
	output logic clk_high_fault
);
	import asop_pkg::*;

	// Buffer fill levels and the depth at which an overlong high phase is flagged
	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam logic [1:0] BUF_FULL = 2'h2;
	localparam int FAULT_DEPTH = HIGH_MAX_CYC + 1;

	// The forced overrange word is a fixed constant, so only a ten-bit code is served
	if (CODE_WIDTH != CODE_W) begin : g_width_check
		$error("asop_port: only a ten-bit code is supported");
	end
	// The high-phase counter must reach its limit without wrapping
	if (HIGH_MAX_CYC >= (1 << CNT_W)) begin : g_count_check
		$error("asop_port: high-phase limit does not fit the counter");
	end
	// Words are paired with the previous sample only, a latency of exactly one
	if (SAMPLE_LATENCY != 1) begin : g_latency_check
		$error("asop_port: only a latency of one sample is supported");
	end

	// Pin synchronisers; stage one is read only by stage two
	logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
	logic [CODE_W-1:0] lvl_s1_ff, lvl_s2_ff;
	logic ovr_s1_ff, ovr_s2_ff;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			clk_s1_ff <= 1'b0;
			clk_s2_ff <= 1'b0;
			clk_s3_ff <= 1'b0;
			lvl_s1_ff <= CODE_ZERO;
			lvl_s2_ff <= CODE_ZERO;
			ovr_s1_ff <= 1'b0;
			ovr_s2_ff <= 1'b0;
		end else begin
			clk_s1_ff <= sample_clk;
			clk_s2_ff <= clk_s1_ff;
			clk_s3_ff <= clk_s2_ff;
			lvl_s1_ff <= analog_level;
			lvl_s2_ff <= lvl_s1_ff;
			ovr_s1_ff <= analog_over;
			ovr_s2_ff <= ovr_s1_ff;
		end
	end

	logic rise;
	assign rise = clk_s2_ff & ~clk_s3_ff;

	// Overrange forces all ones; otherwise the level is the straight binary code
	function automatic logic [CODE_W:0] asop_encode(input logic [CODE_W-1:0] lvl,
		input logic over);
		if (over) begin
			asop_encode = {1'b1, CODE_ONES};
		end else begin
			asop_encode = {1'b0, lvl};
		end
	endfunction

	// Sample register: held from one rising edge to the next
	logic [CODE_W:0] sample_ff;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sample_ff <= {1'b0, CODE_ZERO};
		end else if (rise) begin
			sample_ff <= asop_encode(lvl_s2_ff, ovr_s2_ff);
		end
	end

	property p_sample_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(rise) |-> $stable(sample_ff);
	endproperty
	a_sample_hold: assert property (p_sample_hold)
		else $error("sample changed without a clock edge");

	property p_sample_capture;
		@(posedge clk_sys) disable iff (sys_rst)
		rise && !ovr_s2_ff |=> sample_ff == {1'h0, $past(lvl_s2_ff)};
	endproperty
	a_sample_capture: assert property (p_sample_capture)
		else $error("sample not captured on rising edge");

	property p_sample_over;
		@(posedge clk_sys) disable iff (sys_rst)
		rise && ovr_s2_ff |=> sample_ff == {1'h1, CODE_ONES};
	endproperty
	a_sample_over: assert property (p_sample_over)
		else $error("overrange sample wrong");

	// Two-entry buffer between the sample register and the output register.
	// A stalled receiver loses no word until both entries and the output are full;
	// after that a new rise cannot push, and the previous edge's sample it overwrites in the sample register is dropped.
	logic [CODE_W:0] buf_ff [2];
	logic [1:0] cnt_ff;
	logic rd_ptr_ff, wr_ptr_ff;
	logic out_free, push, pop;
	assign out_free = !result_valid || result_ready;
	assign push = rise && (cnt_ff != BUF_FULL);
	// A word leaves the buffer when the output register takes it, not at the handshake
	assign pop = out_free && (cnt_ff != BUF_EMPTY);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_ff <= BUF_EMPTY;
			rd_ptr_ff <= 1'h0;
			wr_ptr_ff <= 1'h0;
		end else begin
			// The word pushed is the previous edge's sample
			if (push) begin
				buf_ff[wr_ptr_ff] <= sample_ff;
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
			cnt_ff <= cnt_ff + {1'h0, push} - {1'h0, pop};
		end
	end

	property p_push_prev;
		@(posedge clk_sys) disable iff (sys_rst)
		push |=> buf_ff[$past(wr_ptr_ff)] == $past(sample_ff);
	endproperty
	a_push_prev: assert property (p_push_prev)
		else $error("buffered word is not the previous sample");

	property p_count_bound;
		@(posedge clk_sys) disable iff (sys_rst)
		cnt_ff <= BUF_FULL;
	endproperty
	a_count_bound: assert property (p_count_bound)
		else $error("buffer count overflow");

	// A word pushed into an empty buffer with a free output stands two edges later
	sequence s_push_idle;
		push && cnt_ff == BUF_EMPTY && out_free;
	endsequence
	sequence s_word_shown;
		result_valid && {overrange_flag, conversion_code} == $past(sample_ff, 2);
	endsequence
	property p_word_latency;
		@(posedge clk_sys) disable iff (sys_rst)
		s_push_idle |-> ##2 s_word_shown;
	endproperty
	a_word_latency: assert property (p_word_latency)
		else $error("word not shown two edges after its push");

	// Output register: loads a word only when free, then stands until it is taken
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			conversion_code <= CODE_ZERO;
			overrange_flag <= 1'h0;
			result_valid <= 1'h0;
		end else if (out_free) begin
			result_valid <= pop;
			if (pop) begin
				{overrange_flag, conversion_code} <= buf_ff[rd_ptr_ff];
			end
		end
	end

	property p_over_ones;
		@(posedge clk_sys) disable iff (sys_rst)
		result_valid && overrange_flag |-> conversion_code == CODE_ONES;
	endproperty
	a_overrange_ones: assert property (p_over_ones)
		else $error("overrange without all-ones code");

	property p_out_stall;
		@(posedge clk_sys) disable iff (sys_rst)
		result_valid && !result_ready |=> result_valid && $stable(conversion_code)
			&& $stable(overrange_flag);
	endproperty
	a_out_stall: assert property (p_out_stall)
		else $error("output changed during stall");

	// Outputs leave reset empty, so no stale word is offered after a mid-run reset
	property p_reset_quiet;
		@(posedge clk_sys)
		$fell(sys_rst) |-> !result_valid && !overrange_flag && conversion_code == CODE_ZERO;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("output word offered straight after reset");

	// High phase longer than the track/hold allows is flagged
	logic [CNT_W-1:0] high_cnt_ff;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			high_cnt_ff <= CNT_ZERO;
			clk_high_fault <= 1'b0;
		end else begin
			high_cnt_ff <= clk_s2_ff ? ((high_cnt_ff == CNT_HIGH_MAX) ? high_cnt_ff
				: high_cnt_ff + 4'h1) : CNT_ZERO;
			clk_high_fault <= clk_s2_ff && (high_cnt_ff == CNT_HIGH_MAX);
		end
	end

	property p_high_fault;
		@(posedge clk_sys) disable iff (sys_rst)
		!clk_s2_ff |=> !clk_high_fault;
	endproperty
	a_high_fault: assert property (p_high_fault)
		else $error("high fault with clock low");

	// The fault may only rise once the synchronised clock stood high past the limit
	sequence s_long_high;
		$past(clk_s2_ff, FAULT_DEPTH) && $past(clk_s2_ff);
	endsequence
	property p_fault_late;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(clk_high_fault) |-> s_long_high;
	endproperty
	a_fault_late: assert property (p_fault_late)
		else $error("high fault raised before the limit");
endmodule

`default_nettype wire

// ===== tb/asop_cap.sv
// Capturing logic model: drives the sampling clock and latches result words
`timescale 1ns/1ps
`default_nettype none
module asop_cap import asop_pkg::*; (
	// Clock and stream
	input wire logic clk_sys,
	output logic sample_clk,
	input wire logic [asop_pkg::CODE_W-1:0] conversion_code,
	input wire logic overrange_flag,
	input wire logic result_valid,
	output logic result_ready
);
	logic hold = 1'b0;
	logic [10:0] got[$];
	initial sample_clk = 1'b0;
	assign result_ready = !hold;
	// Code and flag taken as one word
	always @(posedge clk_sys) begin
		if (result_valid && result_ready) got.push_back({overrange_flag, conversion_code});
	end
	// High hi cycles, low three; hi of 2 or 3 keeps duty within 40 to 60 percent
	task automatic pulse(input int hi);
		sample_clk <= 1'b1;
		repeat (hi) @(posedge clk_sys);
		sample_clk <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the converter sample output port
`timescale 1ns/1ps
`default_nettype none
module tb;
	import asop_pkg::*;
	typedef struct {logic [9:0] l; logic o; logic [10:0] x;} asop_row_t;
	logic clk_sys, sys_rst, sample_clk, analog_over, overrange_flag;
	logic result_valid, result_ready, clk_high_fault;
	logic [CODE_W-1:0] analog_level, conversion_code;
	logic [10:0] exp_q[$];
	logic [10:0] prev;
	int error_cnt, comparisons;
	asop_row_t rows[5] = '{'{10'h000, 1'b0, 11'h000}, '{10'h001, 1'b0, 11'h001},
		'{10'h3FE, 1'b0, 11'h3FE}, '{10'h3FF, 1'b0, 11'h3FF}, '{10'h155, 1'b1, 11'h7FF}};
	asop_port DUT (.clk_sys, .sys_rst, .sample_clk, .analog_level, .analog_over,
		.conversion_code, .overrange_flag, .result_valid, .result_ready, .clk_high_fault);
	asop_cap cap (.clk_sys, .sample_clk, .conversion_code, .overrange_flag,
		.result_valid, .result_ready);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic check(input string n, input logic [10:0] s, input logic [10:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// The word out after a rise is the one sampled at the rise before
	task automatic samp(input asop_row_t r, input int hi);
		analog_level <= r.l;
		analog_over <= r.o;
		cap.pulse(hi);
		exp_q.push_back(prev);
		prev = r.x;
	endtask
	task automatic drain;
		int n;
		n = 0;
		while (cap.got.size() < exp_q.size()) begin
			@(posedge clk_sys);
			n++;
			if (n == 200) begin
				error_cnt++;
				tally_and_finish();
			end
		end
		while (exp_q.size() > 0) check("word", cap.got.pop_front(), exp_q.pop_front());
		repeat (8) @(posedge clk_sys);
		check("extra", 11'(cap.got.size()), 11'h000);
	endtask
	initial begin
		sys_rst = 1'b1;
		analog_level = 10'h000;
		analog_over = 1'b0;
		prev = 11'h000;
		repeat (20) @(posedge clk_sys);
		#1 check("valid_rst", {10'h000, result_valid}, 11'h000);
		@(posedge clk_sys) sys_rst <= 1'b0;
		foreach (rows[i]) samp(rows[i], 3);
		drain();
		// Stalled receiver: the output word and both buffer entries wait unchanged
		cap.hold <= 1'b1;
		samp('{10'h2AA, 1'b0, 11'h2AA}, 2);
		samp('{10'h0F0, 1'b0, 11'h0F0}, 2);
		samp('{10'h055, 1'b0, 11'h055}, 2);
		#1 check("held", {overrange_flag, conversion_code}, 11'h7FF);
		repeat (5) @(posedge clk_sys);
		#1 check("held", {overrange_flag, conversion_code}, 11'h7FF);
		@(posedge clk_sys) cap.hold <= 1'b0;
		drain();
		// Overlong high phase must raise the width fault
		fork
			samp('{10'h100, 1'b0, 11'h100}, 14);
			begin
				repeat (13) @(posedge clk_sys);
				#1 check("fault", {10'h000, clk_high_fault}, 11'h001);
			end
		join
		samp('{10'h200, 1'b0, 11'h200}, 2);
		#1 check("fault", {10'h000, clk_high_fault}, 11'h000);
		drain();
		// Mid-run reset drops the stalled word; the first word after it is the reset sample
		cap.hold <= 1'b1;
		samp('{10'h123, 1'b0, 11'h123}, 2);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 check("valid_mid", {10'h000, result_valid}, 11'h000);
		check("word_mid", {overrange_flag, conversion_code}, 11'h000);
		@(posedge clk_sys) begin
			sys_rst <= 1'b0;
			cap.hold <= 1'b0;
		end
		exp_q.delete();
		prev = 11'h000;
		samp('{10'h0AB, 1'b0, 11'h0AB}, 3);
		samp('{10'h354, 1'b1, 11'h7FF}, 3);
		drain();
		tally_and_finish();
	end
endmodule
`default_nettype wire
